// ==== test/bsc_link_assertions.sv ====
// pin-level assertions on the controller to sram link
`timescale 1ns/1ps
module bsc_link_chk (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // link
    input wire logic rst_n,
    input wire logic clk_run,
    input wire logic burst_start_strobe_n,
    input wire logic write_n,
    input wire logic dq_host_oe,
    input wire logic dq_dev_oe,
    input wire logic data_strobe_a,
    input wire logic data_strobe_b,
    input wire logic strobe_oe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic [3:0] up_reg;
    logic [2:0] beat_reg;
    // saturating, so a long run never wraps back under eight
    always_ff @(posedge core_clk) begin
        if (sys_rst || !rst_n) up_reg <= 4'h0;
        else if (up_reg != 4'hf) up_reg <= up_reg + 4'h1;
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) beat_reg <= 3'h0;
        else if (!burst_start_strobe_n && !write_n) beat_reg <= 3'h1;
        else if (beat_reg != 3'h0 && beat_reg != 3'h4) beat_reg <= beat_reg + 3'h1;
        else beat_reg <= 3'h0;
    end
    chk_reset_wait: assert property (!burst_start_strobe_n |-> up_reg >= 4'h8)
        else $error("burst started too soon after reset");
    chk_strobe_pair: assert property (strobe_oe |-> data_strobe_a != data_strobe_b)
        else $error("strobes not complementary");
    chk_strobe_toggle: assert property (strobe_oe && $past(strobe_oe)
        |-> data_strobe_a != $past(data_strobe_a))
        else $error("strobe missed a toggle");
    chk_strobe_hiz: assert property ((!burst_start_strobe_n && write_n)
        |-> ##3 strobe_oe [*4] ##1 !strobe_oe)
        else $error("strobes still driven after read burst");
    chk_clock_demand: assert property ((!burst_start_strobe_n || dq_host_oe || dq_dev_oe)
        |-> clk_run)
        else $error("clock released during a burst");
    chk_read_latency: assert property ((!burst_start_strobe_n && write_n)
        |-> ##3 dq_dev_oe [*4] ##1 !dq_dev_oe)
        else $error("read burst timing wrong");
    chk_write_gap: assert property ((!burst_start_strobe_n && !write_n)
        |-> ##1 burst_start_strobe_n [*5])
        else $error("no idle cycle after write burst");
    chk_mask_hold: assert property (beat_reg > 3'h1 && $past(write_n) |-> write_n)
        else $error("write pin dropped after masking");
    chk_beat_drive: assert property (beat_reg != 3'h0 && !write_n |-> dq_host_oe)
        else $error("write beat without data driven");
    cover property (!burst_start_strobe_n && write_n);
    cover property (!burst_start_strobe_n && !write_n);
    cover property (beat_reg != 3'h0 && $rose(write_n));
endmodule

// ==== test/tb_top.sv ====
// self-checking bench joining the controller and sram ends
`timescale 1ns/1ps
module tb_top;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic req_valid = 1'b0, req_write = 1'b0, req_ready, wr_data_take, rd_valid, dev_ready;
    logic [15:0] req_addr = 16'h0, a;
    logic [2:0] req_wr_beats = 3'h0;
    logic [35:0] wr_data = 36'h0, rd_data;
    logic [35:0] wbuf [4], mem [65536], exp_q [$];
    logic [1:0] widx = 2'h0;
    int n_mismatch = 0, samples_checked = 0, n;
    bsc_if i_bsc_if ();
    bsc_dev i_bsc_dev (.core_clk(core_clk), .sys_rst(sys_rst), .link(i_bsc_if.dev),
        .ready(dev_ready));
    bsc_host i_bsc_host (.core_clk(core_clk), .sys_rst(sys_rst), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
        .req_wr_beats(req_wr_beats), .wr_data(wr_data), .wr_data_take(wr_data_take),
        .rd_data(rd_data), .rd_valid(rd_valid), .link(i_bsc_if.host));
    bsc_link_chk i_bsc_link_chk (.core_clk(core_clk), .sys_rst(sys_rst),
        .rst_n(i_bsc_if.rst_n), .clk_run(i_bsc_if.clk_run),
        .burst_start_strobe_n(i_bsc_if.burst_start_strobe_n),
        .write_n(i_bsc_if.write_n), .dq_host_oe(i_bsc_if.dq_host_oe),
        .dq_dev_oe(i_bsc_if.dq_dev_oe), .data_strobe_a(i_bsc_if.data_strobe_a),
        .data_strobe_b(i_bsc_if.data_strobe_b), .strobe_oe(i_bsc_if.strobe_oe));
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    task automatic check(input logic [35:0] seen, input logic [35:0] want);
        samples_checked++;
        if (seen !== want) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic final_report();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // burst counter wraps inside the aligned four-word block
    function automatic logic [15:0] off(input logic [15:0] b, input logic [1:0] o);
        return {b[15:2], b[1:0] + o};
    endfunction
    task automatic issue(input logic w, input logic [15:0] b, input logic [2:0] nb);
        int k;
        @(posedge core_clk);
        req_valid <= 1'b1;
        req_write <= w;
        req_addr <= b;
        req_wr_beats <= nb;
        k = 0;
        do @(negedge core_clk); while (!req_ready && ++k < 200);
        // refill only once the previous burst has let go of the buffer
        for (k = 0; k < 4; k++) wbuf[k] = 36'({$urandom(), $urandom()});
        @(posedge core_clk);
        req_valid <= 1'b0;
        for (k = 0; k < 4; k++) begin
            if (w && k < nb) mem[off(b, k[1:0])] = wbuf[k];
            if (!w) exp_q.push_back(mem[off(b, k[1:0])]);
        end
    endtask
    always @(posedge core_clk) begin
        if (req_valid && req_ready) begin
            widx <= 2'h0;
            wr_data <= wbuf[0];
        end else if (wr_data_take) begin
            widx <= widx + 2'h1;
            wr_data <= wbuf[widx + 2'h1];
        end
        if (rd_valid) check(rd_data, exp_q.size() != 0 ? exp_q.pop_front() : 'x);
    end
    initial begin
        void'($urandom(32'h9806e742));
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(negedge core_clk);
        check(i_bsc_if.strobe_oe, 36'h0);
        check(i_bsc_if.burst_start_strobe_n, 36'h1);
        check(dev_ready, 36'h0);
        $display("test reset done");
        for (n = 0; n <= 4; n++) begin
            a = 16'($urandom());
            issue(1'b1, a, 3'h4);
            issue(1'b1, off(a, n[1:0]), n[2:0]);
            issue(1'b0, off(a, 2'($urandom_range(3))), 3'h0);
        end
        $display("test masked writes done");
        issue(1'b0, a, 3'h0);
        issue(1'b0, off(a, 2'h3), 3'h0);
        for (n = 0; n < 100 && exp_q.size() != 0; n++) @(posedge core_clk);
        check(36'(exp_q.size()), 36'h0);
        check(dev_ready, 36'h1);
        $display("test back-to-back reads done");
        final_report();
    end
    initial begin
        #(50 * 3000);
        n_mismatch++;
        final_report();
    end
endmodule

// ==== verilog/bsc_dev.sv ====
// burst sram device end: burst decode, array, read pipe, strobes
`timescale 1ns/1ps
`include "bsc_map.svh"
module bsc_dev import bsc_pkg::*; #(
    parameter int AW = 16,
    parameter int DW = 36,
    parameter int DEPTH = 65536
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // link
    bsc_if.dev link,
    // status
    output logic ready
);
    typedef struct packed {
        bsc_state_t st;
        logic [3:0] rst_cnt;
        logic [AW-1:0] base;
        logic [1:0] beat;
        logic masked;
        logic [3:0] rd_v;
        logic [AW-1:0] rd_a0;
        logic [DW-1:0] q;
        logic q_v;
        logic stb;
    } bsc_dev_s_t;

    bsc_dev_s_t s_reg, s_next;
    logic [DW-1:0] mem [DEPTH];
    logic [DW-1:0] rd_word;
    logic wr_en;
    logic [AW-1:0] wr_addr;

    function automatic logic [AW-1:0] burst_addr(input logic [AW-1:0] b, input logic [1:0] c);
        burst_addr = {b[AW-1:2], b[1:0] + c};
    endfunction

    always_comb begin
        s_next = s_reg;
        wr_en = 1'b0;
        wr_addr = burst_addr(s_reg.base, s_reg.beat);
        // reset ends only on the released pin, then a fixed settle count
        if (!link.rst_n) begin
            s_next.rst_cnt = 4'h0;
        end else if (s_reg.rst_cnt != `BSC_RST_WAIT) begin
            s_next.rst_cnt = s_reg.rst_cnt + 4'h1;
        end
        s_next.rd_v = {s_reg.rd_v[2:0], 1'b0};
        unique case (s_reg.st)
            BSC_IDLE: begin
                if (ready && !link.burst_start_strobe_n) begin
                    s_next.base = link.addr;
                    s_next.beat = 2'h0;
                    s_next.masked = 1'b0;
                    if (!link.write_n) begin
                        s_next.st = BSC_WR;
                    end else begin
                        s_next.st = BSC_RD;
                        s_next.rd_v[0] = 1'b1;
                    end
                end
            end
            BSC_WR: begin
                // once masked, tail stays masked regardless of pin
                s_next.masked = s_reg.masked | link.write_n;
                wr_en = !(s_reg.masked | link.write_n);
                s_next.beat = s_reg.beat + 2'h1;
                if (s_reg.beat == 2'h3) begin
                    s_next.st = BSC_GAP;
                end
            end
            BSC_RD: begin
                s_next.beat = s_reg.beat + 2'h1;
                if (s_reg.beat != 2'h3) begin
                    s_next.rd_v[0] = 1'b1;
                end else begin
                    s_next.st = BSC_IDLE;
                end
            end
            BSC_GAP: begin
                s_next.st = BSC_IDLE;
            end
        endcase
        // array read takes one edge, output register a second: word lands after rd_v[1]
        s_next.q_v = s_reg.rd_v[1];
        s_next.q = rd_word;
        s_next.stb = s_reg.rd_v[1] ? ~s_reg.stb : s_reg.stb;
        if (!s_reg.q_v && !s_reg.rd_v[1]) begin
            s_next.stb = 1'b0;
        end
    end

    // array read address follows the burst counter
    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= link.dq_host_out;
        end
        rd_word <= mem[burst_addr(s_reg.base, s_reg.beat)];
    end

    // only the clock moves state, so a halted clock holds everything
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s_reg <= '0;
            s_reg.st <= BSC_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign ready = (s_reg.rst_cnt == `BSC_RST_WAIT);
    assign link.dq_dev_out = s_reg.q;
    assign link.dq_dev_oe = s_reg.q_v;
    assign link.data_strobe_a = s_reg.stb;
    assign link.data_strobe_b = ~s_reg.stb;
    assign link.strobe_oe = s_reg.q_v;
endmodule

// ==== verilog/bsc_host.sv ====
// cache controller end: reset sequencing and burst issue
`timescale 1ns/1ps
`include "bsc_map.svh"
module bsc_host import bsc_pkg::*; #(
    parameter int AW = 16,
    parameter int DW = 36
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // user request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [AW-1:0] req_addr,
    input wire logic [2:0] req_wr_beats,
    input wire logic [DW-1:0] wr_data,
    output logic wr_data_take,
    // user read answer
    output logic [DW-1:0] rd_data,
    output logic rd_valid,
    // link
    bsc_if.host link
);
    typedef struct packed {
        bsc_state_t st;
        logic rst_n;
        logic [3:0] rst_cnt;
        logic [1:0] prep;
        logic [1:0] beat;
        logic [2:0] keep;
        logic ads_n;
        logic we_n;
        logic [AW-1:0] addr;
        logic [DW-1:0] d;
        logic d_oe;
        logic [DW-1:0] rd;
        logic rd_v;
    } bsc_host_s_t;

    bsc_host_s_t s_reg, s_next;
    logic clk_need;

    // clock wanted while starting up, busy, draining reads or asked for
    assign clk_need = s_reg.rst_n && (req_valid || s_reg.st != BSC_IDLE || !s_reg.ads_n
        || link.dq_dev_oe || s_reg.rst_cnt != `BSC_RST_WAIT);

    always_comb begin
        s_next = s_reg;
        s_next.rst_n = 1'b1;
        s_next.ads_n = 1'b1;
        s_next.d_oe = 1'b0;
        s_next.rd_v = 1'b0;
        s_next.rd = link.dq_dev_out;
        if (s_reg.rst_n && s_reg.rst_cnt != `BSC_RST_WAIT) begin
            s_next.rst_cnt = s_reg.rst_cnt + 4'h1;
        end
        // a restarted clock must give two good edges before any strobe
        if (!clk_need) begin
            s_next.prep = 2'h0;
        end else if (s_reg.prep != `BSC_CLK_PREP) begin
            s_next.prep = s_reg.prep + 2'h1;
        end
        if (link.dq_dev_oe) begin
            s_next.rd_v = 1'b1;
        end
        wr_data_take = 1'b0;
        unique case (s_reg.st)
            BSC_IDLE: begin
                s_next.we_n = 1'b1;
                s_next.addr = '0;
                if (req_ready && req_valid) begin
                    s_next.ads_n = 1'b0;
                    s_next.addr = req_addr;
                    s_next.we_n = !req_write;
                    s_next.keep = req_wr_beats;
                    s_next.beat = 2'h0;
                    s_next.st = req_write ? BSC_WR : BSC_RD;
                end
            end
            BSC_WR: begin
                wr_data_take = 1'b1;
                s_next.d = wr_data;
                s_next.d_oe = 1'b1;
                // high from the first dropped beat to burst end
                s_next.we_n = ({1'b0, s_reg.beat} >= s_reg.keep);
                s_next.beat = s_reg.beat + 2'h1;
                if (s_reg.beat == 2'h3) begin
                    s_next.st = BSC_GAP;
                end
            end
            BSC_RD: begin
                s_next.beat = s_reg.beat + 2'h1;
                if (s_reg.beat == 2'h3) begin
                    s_next.st = BSC_IDLE;
                end
            end
            BSC_GAP: begin
                s_next.we_n = 1'b1;
                s_next.d_oe = 1'b0;
                s_next.addr = '0;
                s_next.st = BSC_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s_reg <= '0;
            s_reg.st <= BSC_IDLE;
            s_reg.ads_n <= 1'b1;
            s_reg.we_n <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign req_ready = (s_reg.st == BSC_IDLE) && s_reg.ads_n && s_reg.rst_cnt == `BSC_RST_WAIT
        && s_reg.prep == `BSC_CLK_PREP && !link.dq_dev_oe;
    assign rd_data = s_reg.rd;
    assign rd_valid = s_reg.rd_v;
    assign link.rst_n = s_reg.rst_n;
    assign link.clk_run = clk_need;
    assign link.burst_start_strobe_n = s_reg.ads_n;
    assign link.write_n = s_reg.we_n;
    assign link.addr = s_reg.addr;
    assign link.dq_host_out = s_reg.d;
    assign link.dq_host_oe = s_reg.d_oe;
endmodule

// ==== verilog/bsc_if.sv ====
// pin-level link between cache controller and burst sram
`timescale 1ns/1ps
interface bsc_if #(parameter int AW = 16, parameter int DW = 36);
    logic rst_n;
    logic clk_run;
    logic burst_start_strobe_n;
    logic write_n;
    logic [AW-1:0] addr;
    logic [DW-1:0] dq_host_out;
    logic dq_host_oe;
    logic [DW-1:0] dq_dev_out;
    logic dq_dev_oe;
    logic data_strobe_a;
    logic data_strobe_b;
    logic strobe_oe;
    modport dev (input rst_n, clk_run, burst_start_strobe_n, write_n, addr, dq_host_out,
        dq_host_oe, output dq_dev_out, dq_dev_oe, data_strobe_a, data_strobe_b, strobe_oe);
    modport host (output rst_n, clk_run, burst_start_strobe_n, write_n, addr, dq_host_out,
        dq_host_oe, input dq_dev_out, dq_dev_oe, data_strobe_a, data_strobe_b, strobe_oe);
endinterface

// ==== verilog/bsc_map.svh ====
// constants and timing counts for the burst sram cycle link
`ifndef BSC_MAP_SVH
`define BSC_MAP_SVH
`define BSC_RST_WAIT 4'h8
`define BSC_BURST_LEN 3'h4
`define BSC_CLK_PREP 2'h2
`define BSC_RD_LAT 2'h2
`endif

// ==== verilog/bsc_pkg.sv ====
// types shared by both ends of the burst sram link
package bsc_pkg;
    typedef enum logic [3:0] {
        BSC_IDLE = 4'b0001,
        BSC_WR = 4'b0010,
        BSC_RD = 4'b0100,
        BSC_GAP = 4'b1000
    } bsc_state_t;
endpackage
